//--- rtl/pllcr_top.sv
// pll controller register block: identification, control, multiplier, pre-divider
// assumes an apb3 master on CLK_SYS_I and a pll macro fed by the registered outputs
module pllcr_top
   import pllcr_pkg::*;
#(
   parameter bit SECOND_INSTANCE = 1'b0,
   parameter logic [7:0] TYPE_CODE = 8'h2a, // arbitrary value
   parameter logic [7:0] CLASS_CODE = 8'h3c, // arbitrary value
   parameter logic [7:0] REVISION_CODE = 8'h11 // arbitrary value
) (
   // clock, reset, clock enable
   input wire logic CLK_SYS_I,
   input wire logic RESETN_I,
   input wire logic CLK_EN_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [9:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // test hardware
   input wire logic TEST_PLL_EN_I,
   // pll controls
   output logic REF_CLK_SEL_O,
   output logic PLL_DISABLE_O,
   output logic PLL_RESET_O,
   output logic PLL_POWER_DOWN_O,
   output logic PLL_MODE_O,
   output logic [MULT_W-1:0] MULT_FIELD_O,
   output logic [PDV_RATIO_W-1:0] REFERENCE_PRE_DIVIDER_RATIO_O,
   output logic REFERENCE_PRE_DIVIDER_EN_O
);
   localparam logic [MULT_W-1:0] RST_MULT = SECOND_INSTANCE ? RST_MULT_SECOND : RST_MULT_FIRST;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // address to register select
   function automatic pllcr_sel_e decode(input logic [9:0] a);
      case (a)
         OFS_IDENT: decode = SEL_IDENT;
         OFS_CTRL: decode = SEL_CTRL;
         OFS_STATUS: decode = SEL_STATUS;
         OFS_MULT: decode = SEL_MULT;
         OFS_REFERENCE_PRE_DIVIDER: decode = SEL_REFERENCE_PRE_DIVIDER;
         default: decode = SEL_NONE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   logic clk_sel_q, clk_sel_d;
   logic en_src_q, en_src_d;
   logic dis_q, dis_d;
   logic rst_q, rst_d;
   logic pwrdn_q, pwrdn_d;
   logic mode_en_q, mode_en_d;
   logic [MULT_W-1:0] mult_q, mult_d;
   logic mult_rej_q, mult_rej_d;
   logic [PDV_RATIO_W-1:0] pdv_q, pdv_d;
   logic ready_q, ready_d;
   logic err_q, err_d;
   logic [31:0] rdata_q, rdata_d;
   logic ref_sel_q, ref_sel_d;
   logic mode_eff;
   logic test_en_s;
   logic wr_en;
   pllcr_sel_e sel;
   logic [31:0] ctl_word;
   logic [31:0] sts_word;

   assign sel = decode(PADDR_I);
   assign wr_en = PSEL_I && PENABLE_I && ready_q && PWRITE_I;

   // read images; reserved bits zero, fixed bits constant
   always_comb begin
      ctl_word = '0;
      ctl_word[CTL_CLK_SEL] = clk_sel_q; // [R2]
      ctl_word[CTL_FIXED_ONE] = 1'b1; // [R7] [R16]
      ctl_word[CTL_EN_SRC] = en_src_q;
      ctl_word[CTL_DIS] = dis_q;
      ctl_word[CTL_RST] = rst_q;
      ctl_word[CTL_PWRDN] = pwrdn_q;
      ctl_word[CTL_MODE_EN] = mode_en_q;
      sts_word = '0;
      sts_word[STS_MODE] = mode_eff;
      sts_word[STS_TEST_EN] = test_en_s;
      sts_word[STS_MULT_REJ] = mult_rej_q;
   end

   // register write next values
   always_comb begin
      clk_sel_d = clk_sel_q;
      en_src_d = en_src_q;
      dis_d = dis_q;
      rst_d = rst_q;
      pwrdn_d = pwrdn_q;
      mode_en_d = mode_en_q;
      mult_d = mult_q;
      mult_rej_d = mult_rej_q;
      pdv_d = pdv_q;
      if (wr_en) begin
         case (sel)
            SEL_CTRL: begin
               clk_sel_d = PWDATA_I[CTL_CLK_SEL];
               en_src_d = PWDATA_I[CTL_EN_SRC]; // [R3]
               dis_d = PWDATA_I[CTL_DIS]; // [R6]
               rst_d = PWDATA_I[CTL_RST]; // [R6]
               pwrdn_d = PWDATA_I[CTL_PWRDN]; // [R5]
               mode_en_d = PWDATA_I[CTL_MODE_EN]; // [R4]
            end
            SEL_MULT: begin
               // out-of-range factors are dropped and flagged
               if (PWDATA_I[MULT_W-1:0] >= MULT_MIN && PWDATA_I[MULT_W-1:0] <= MULT_MAX) begin // [R8] [R9]
                  mult_d = PWDATA_I[MULT_W-1:0];
                  mult_rej_d = 1'b0;
               end else begin
                  mult_rej_d = 1'b1;
               end
            end
            SEL_REFERENCE_PRE_DIVIDER: begin
               if (SECOND_INSTANCE) begin
                  pdv_d = PWDATA_I[PDV_RATIO_W-1:0]; // [R10] [R11]
               end
            end
            default: begin
               // identification, status and holes ignore writes [R16]
            end
         endcase
      end
   end

   // control registers
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         clk_sel_q <= RST_CLK_SEL; // [R7]
         en_src_q <= RST_EN_SRC;
         dis_q <= RST_DIS;
         rst_q <= RST_RST;
         pwrdn_q <= RST_PWRDN;
         mode_en_q <= RST_MODE_EN;
         mult_q <= RST_MULT; // [R9]
         mult_rej_q <= 1'b0;
         pdv_q <= RST_PDV_RATIO; // [R11]
      end else if (CLK_EN_I) begin
         clk_sel_q <= clk_sel_d;
         en_src_q <= en_src_d;
         dis_q <= dis_d;
         rst_q <= rst_d;
         pwrdn_q <= pwrdn_d;
         mode_en_q <= mode_en_d;
         mult_q <= mult_d;
         mult_rej_q <= mult_rej_d;
         pdv_q <= pdv_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // apb answer: no wait state, registered ready, data and error

   always_comb begin
      ready_d = PSEL_I && !PENABLE_I;
      err_d = PSEL_I && !PENABLE_I && (sel == SEL_NONE);
      rdata_d = rdata_q;
      if (PSEL_I && !PENABLE_I) begin
         case (sel)
            SEL_IDENT: rdata_d = {8'h00, TYPE_CODE, CLASS_CODE, REVISION_CODE}; // [R1]
            SEL_CTRL: rdata_d = ctl_word;
            SEL_STATUS: rdata_d = sts_word;
            SEL_MULT: rdata_d = {24'h000000, mult_q}; // [R8]
            SEL_REFERENCE_PRE_DIVIDER: begin
               rdata_d = '0;
               rdata_d[PDV_EN] = 1'b1; // [R12]
               rdata_d[PDV_RATIO_W-1:0] = pdv_q; // [R10]
            end
            default: rdata_d = '0;
         endcase
      end
   end

   // bus answer registers
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ready_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= '0;
      end else if (CLK_EN_I) begin
         ready_q <= ready_d;
         err_q <= err_d;
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pll side

   // effective mode from register bit or test hardware
   pllcr_mode_mux i_pllcr_mode_mux (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RESETN_I),
      .ce_i(CLK_EN_I),
      .en_src_i(en_src_q),
      .mode_en_i(mode_en_q),
      .test_en_i(TEST_PLL_EN_I),
      .mode_o(mode_eff),
      .test_en_o(test_en_s)
   );

   // reference select is pinned low in the second instance
   always_comb begin
      ref_sel_d = SECOND_INSTANCE ? RST_CLK_SEL : clk_sel_q; // [R2]
   end

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ref_sel_q <= RST_CLK_SEL;
      end else if (CLK_EN_I) begin
         ref_sel_q <= ref_sel_d;
      end
   end

   assign PRDATA_O = rdata_q;
   assign PREADY_O = ready_q;
   assign PSLVERR_O = err_q;
   assign REF_CLK_SEL_O = ref_sel_q;
   assign PLL_DISABLE_O = dis_q; // [R6]
   assign PLL_RESET_O = rst_q; // [R6]
   assign PLL_POWER_DOWN_O = pwrdn_q; // [R5]
   assign PLL_MODE_O = mode_eff; // [R4]
   assign MULT_FIELD_O = mult_q;
   assign REFERENCE_PRE_DIVIDER_RATIO_O = pdv_q;
   assign REFERENCE_PRE_DIVIDER_EN_O = 1'b1; // [R12]
endmodule // pllcr_top

//--- rtl/pllcr_pkg.sv
// constants for the pll controller register block: map, fields, reset values
// assumes a 32-bit apb slave with byte addresses inside a 1 kbyte window
//
// Notes on behaviour
// [R1] identification register is read-only: zero, type, class and revision bytes
// [R2] control bit 8 picks oscillator or external clock; ignored in second instance
// [R3] control bit 5 hands mode enable to the register bit or test hardware
// [R4] control bit 0 selects bypass or pll mode, only while bit 5 is clear
// [R5] control bit 1 holds the pll powered down while set
// [R6] control bits 4 and 3 drive pll disable and pll reset, read/write
// [R7] control resets to bypass, pll in reset and powered down, bit 6 one
// [R8] multiplier field bits 7-0 gives factor field plus one, range 5bh to b7h
// [R9] multiplier resets to factor 180 or 92 by instance; accepts 92 to 184
// [R10] pre-divider ratio bits 4-0 divides reference by field plus one
// [R11] pre-divider ratio resets to 7; read-only in first, writable in second
// [R12] pre-divider enable bit 15 is read-only and always one
// [R13] software waits four reference cycles after clearing mode enable
// [R14] software changes multiplier or pre-divider only while in bypass
// [R15] software waits 8000 reference cycles after reset release before pll mode
// [R16] writes to read-only or reserved fields are ignored, fixed values read back
package pllcr_pkg;
   // register byte offsets
   localparam logic [9:0] OFS_IDENT = 10'h000;
   localparam logic [9:0] OFS_CTRL = 10'h100;
   localparam logic [9:0] OFS_STATUS = 10'h104;
   localparam logic [9:0] OFS_MULT = 10'h110;
   localparam logic [9:0] OFS_REFERENCE_PRE_DIVIDER = 10'h114;

   // control field positions
   localparam int CTL_MODE_EN = 0;
   localparam int CTL_PWRDN = 1;
   localparam int CTL_RST = 3;
   localparam int CTL_DIS = 4;
   localparam int CTL_EN_SRC = 5;
   localparam int CTL_FIXED_ONE = 6;
   localparam int CTL_CLK_SEL = 8;

   // status field positions
   localparam int STS_MODE = 0;
   localparam int STS_TEST_EN = 1;
   localparam int STS_MULT_REJ = 2;

   // pre-divider fields and multiplier width
   localparam int PDV_EN = 15;
   localparam int PDV_RATIO_W = 5;
   localparam int MULT_W = 8;

   // reset values
   localparam logic RST_CLK_SEL = 1'b0;
   localparam logic RST_EN_SRC = 1'b1;
   localparam logic RST_DIS = 1'b1;
   localparam logic RST_RST = 1'b1;
   localparam logic RST_PWRDN = 1'b1;
   localparam logic RST_MODE_EN = 1'b0;
   localparam logic [MULT_W-1:0] RST_MULT_FIRST = 8'hb3;
   localparam logic [MULT_W-1:0] RST_MULT_SECOND = 8'h5b;
   localparam logic [PDV_RATIO_W-1:0] RST_PDV_RATIO = 5'h07;

   // legal multiplier field range
   localparam logic [MULT_W-1:0] MULT_MIN = 8'h5b;
   localparam logic [MULT_W-1:0] MULT_MAX = 8'hb7;

   // software settling times, in reference clock cycles
   localparam int BYPASS_SETTLE_REF_CYCLES = 4;
   localparam int LOCK_REF_CYCLES = 8000;

   // register select
   typedef enum {SEL_NONE, SEL_IDENT, SEL_CTRL, SEL_STATUS, SEL_MULT, SEL_REFERENCE_PRE_DIVIDER} pllcr_sel_e;
endpackage

//--- rtl/pllcr_mode_mux.sv
// effective pll mode selection between register bit and test hardware
// assumes test_en_i is asynchronous to clk_i; all other inputs are local
module pllcr_mode_mux
   import pllcr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // selection inputs
   input wire logic en_src_i,
   input wire logic mode_en_i,
   input wire logic test_en_i,
   // results
   output logic mode_o,
   output logic test_en_o
);
   logic sync1_q, sync1_d;
   logic sync2_q, sync2_d;
   logic mode_q, mode_d;

   // next values: two-stage sync, then source mux
   always_comb begin
      sync1_d = test_en_i;
      sync2_d = sync1_q;
      mode_d = en_src_i ? sync2_q : mode_en_i; // [R3] [R4]
   end

   // state registers, frozen while ce_i is low
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         mode_q <= RST_MODE_EN;
      end else if (ce_i) begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         mode_q <= mode_d;
      end
   end

   assign mode_o = mode_q;
   assign test_en_o = sync2_q;
endmodule // pllcr_mode_mux

//--- testbench/pllcr_asserts.sv
// checker for the pll control register block
// bound to every pllcr_top instance; sees only its ports
module pllcr_asserts
   import pllcr_pkg::*;
#(
   parameter bit SECOND_INSTANCE = 1'b0
) (
   // clock, reset, enable
   input wire logic CLK_SYS_I,
   input wire logic RESETN_I,
   input wire logic CLK_EN_I,
   // apb
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [9:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   // pll controls
   input wire logic REF_CLK_SEL_O,
   input wire logic PLL_DISABLE_O,
   input wire logic PLL_RESET_O,
   input wire logic PLL_POWER_DOWN_O,
   input wire logic [MULT_W-1:0] MULT_FIELD_O,
   input wire logic [PDV_RATIO_W-1:0] REFERENCE_PRE_DIVIDER_RATIO_O,
   input wire logic REFERENCE_PRE_DIVIDER_EN_O
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RESETN_I);

   // write commit and multiplier range
   logic wr_go;
   logic in_rng;
   assign wr_go = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && CLK_EN_I;
   assign in_rng = PWDATA_I[7:0] >= MULT_MIN && PWDATA_I[7:0] <= MULT_MAX;

   ////////////////////////////////////////////////////////////////////////////
   a_ready_after_setup: assert property (PSEL_I && !PENABLE_I && CLK_EN_I |=> PREADY_O)
      else $error("no ready after setup");
   a_ready_single: assert property (PREADY_O && CLK_EN_I |=> !PREADY_O)
      else $error("ready longer than one cycle");
   a_err_with_ready: assert property (PSLVERR_O |-> PREADY_O)
      else $error("error without ready");
   a_ctrl_pins: assert property (wr_go && PADDR_I == OFS_CTRL |=>
      {PLL_DISABLE_O, PLL_RESET_O, PLL_POWER_DOWN_O} == {$past(PWDATA_I[4]), $past(PWDATA_I[3]), $past(PWDATA_I[1])})
      else $error("control pins differ from write");
   // the reference select pin is registered once more behind the control bit
   a_clk_sel_pin: assert property (wr_go && PADDR_I == OFS_CTRL |-> ##2
      REF_CLK_SEL_O == ($past(PWDATA_I[CTL_CLK_SEL], 2) && !SECOND_INSTANCE))
      else $error("clock select pin wrong");
   a_mult_taken: assert property (wr_go && PADDR_I == OFS_MULT && in_rng |=>
      MULT_FIELD_O == $past(PWDATA_I[7:0]))
      else $error("multiplier not taken");
   a_mult_refused: assert property (wr_go && PADDR_I == OFS_MULT && !in_rng |=> $stable(MULT_FIELD_O))
      else $error("multiplier out of range taken");
   a_reference_pre_divider_fixed: assert property (!SECOND_INSTANCE |-> REFERENCE_PRE_DIVIDER_RATIO_O == RST_PDV_RATIO)
      else $error("fixed pre-divider changed");
   a_reference_pre_divider_en_one: assert property (REFERENCE_PRE_DIVIDER_EN_O)
      else $error("pre-divider enable low");
endmodule // pllcr_asserts

bind pllcr_top pllcr_asserts #(.SECOND_INSTANCE(SECOND_INSTANCE)) i_pllcr_asserts (
   .CLK_SYS_I, .RESETN_I, .CLK_EN_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PREADY_O,
   .PSLVERR_O, .REF_CLK_SEL_O, .PLL_DISABLE_O, .PLL_RESET_O, .PLL_POWER_DOWN_O, .MULT_FIELD_O,
   .REFERENCE_PRE_DIVIDER_RATIO_O, .REFERENCE_PRE_DIVIDER_EN_O);

//--- testbench/pllcr_bench.sv
// testbench: both controller instances side by side on one apb master
// assumes pllcr_pkg and the checker are compiled first
module pllcr_bench
   import pllcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rstn, cen, psel, pen, pwr, test_en;
   logic [9:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] rd [2];
   logic [31:0] rdat [2];
   logic rdy [2];
   logic err [2];
   logic [31:0] serr [2];
   logic cs [2];
   logic dis [2];
   logic rst [2];
   logic pd [2];
   logic mode [2];
   logic [7:0] mult [2];
   logic [4:0] pdr [2];
   logic pden [2];
   int n_mismatch = 0;
   int total_checks = 0;

   // clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // instance 0 is the first controller, instance 1 the second
   for (genvar g = 0; g < 2; g++) begin : g_inst
      pllcr_top #(.SECOND_INSTANCE(g == 1)) i_pllcr_top (.CLK_SYS_I(clk), .RESETN_I(rstn), .CLK_EN_I(cen),
         .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(rd[g]),
         .PREADY_O(rdy[g]), .PSLVERR_O(err[g]), .TEST_PLL_EN_I(test_en), .REF_CLK_SEL_O(cs[g]),
         .PLL_DISABLE_O(dis[g]), .PLL_RESET_O(rst[g]), .PLL_POWER_DOWN_O(pd[g]), .PLL_MODE_O(mode[g]),
         .MULT_FIELD_O(mult[g]), .REFERENCE_PRE_DIVIDER_RATIO_O(pdr[g]), .REFERENCE_PRE_DIVIDER_EN_O(pden[g]));
   end

   ////////////////////////////////////////////////////////////////////////////
   // compare, verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results();
      if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // one apb transfer; answer taken at the rising edge that samples ready high
   task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rdy[0] !== 1'b1 && n < 50);
      if (n >= 50) chk(32'hdead, 32'h0);
      rdat = rd;
      serr[0] = {31'h0, err[0]};
      serr[1] = {31'h0, err[1]};
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic rdchk(input logic [9:0] a, input logic [31:0] e0, input logic [31:0] e1);
      xfer(1'b0, a, 32'h0);
      chk(rdat[0], e0);
      chk(rdat[1], e1);
      chk({serr[0][0], serr[1][0]}, 32'h0);
   endtask

   // pins {disable, reset, power-down, mode, clock select} after settling
   task automatic pins(input logic [4:0] e0, input logic [4:0] e1);
      repeat (6) @(posedge clk);
      chk({dis[0], rst[0], pd[0], mode[0], cs[0]}, e0);
      chk({dis[1], rst[1], pd[1], mode[1], cs[1]}, e1);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      pins(5'h1c, 5'h1c);
      rdchk(OFS_IDENT, 32'h002a3c11, 32'h002a3c11);
      rdchk(OFS_CTRL, 32'h7a, 32'h7a);
      rdchk(OFS_MULT, 32'hb3, 32'h5b);
      rdchk(OFS_REFERENCE_PRE_DIVIDER, 32'h8007, 32'h8007);
      xfer(1'b1, OFS_IDENT, 32'hffffffff);
      rdchk(OFS_IDENT, 32'h002a3c11, 32'h002a3c11);
      xfer(1'b0, 10'h3fc, 32'h0);
      chk(serr[0], 32'h1);
      chk(serr[1], 32'h1);
      chk(rdat[0], 32'h0);
   endtask

   task automatic t_ctrl();
      xfer(1'b1, OFS_CTRL, 32'hffffffff);
      rdchk(OFS_CTRL, 32'h17b, 32'h17b);
      pins(5'h1d, 5'h1c);
      // clock enable low freezes the test enable path
      cen <= 1'b0;
      test_en <= 1'b1;
      pins(5'h1d, 5'h1c);
      cen <= 1'b1;
      pins(5'h1f, 5'h1e);
      xfer(1'b1, OFS_CTRL, 32'h0);
      pins(5'h00, 5'h00);
      repeat (LOCK_REF_CYCLES) @(posedge clk);
      xfer(1'b1, OFS_CTRL, 32'h1);
      pins(5'h02, 5'h02);
      test_en <= 1'b0;
      xfer(1'b1, OFS_CTRL, 32'h20);
      pins(5'h00, 5'h00);
      repeat (BYPASS_SETTLE_REF_CYCLES) @(posedge clk);
      xfer(1'b1, OFS_CTRL, 32'h28);
      pins(5'h08, 5'h08);
   endtask

   task automatic t_mult();
      logic [7:0] v [4] = '{8'h5b, 8'hb7, 8'h5a, 8'hb8};
      logic [7:0] e [4] = '{8'h5b, 8'hb7, 8'hb7, 8'hb7};
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, OFS_MULT, {24'h0, v[i]}); // bypass and reset set up by t_ctrl
         rdchk(OFS_MULT, {24'h0, e[i]}, {24'h0, e[i]});
         chk(mult[1], e[i]);
         chk(mult[0], e[i]);
      end
      rdchk(OFS_STATUS, 32'h4, 32'h4);
   endtask

   task automatic t_reference_pre_divider();
      xfer(1'b1, OFS_REFERENCE_PRE_DIVIDER, 32'hffffffff);
      rdchk(OFS_REFERENCE_PRE_DIVIDER, 32'h8007, 32'h801f);
      xfer(1'b1, OFS_REFERENCE_PRE_DIVIDER, 32'h0);
      rdchk(OFS_REFERENCE_PRE_DIVIDER, 32'h8007, 32'h8000);
      chk({pdr[0], pdr[1], pden[0], pden[1]}, 12'h383);
   endtask

   // reset in mid-run brings the written fields back
   task automatic t_rerst();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      pins(5'h1c, 5'h1c);
      rdchk(OFS_CTRL, 32'h7a, 32'h7a);
      rdchk(OFS_MULT, 32'hb3, 32'h5b);
      rdchk(OFS_REFERENCE_PRE_DIVIDER, 32'h8007, 32'h8007);
   endtask

   // main sequence
   initial begin
      rstn = 1'b0;
      cen = 1'b1;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 10'h0;
      pwdata = 32'h0;
      test_en = 1'b0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_ctrl();
      t_mult();
      t_reference_pre_divider();
      t_rerst();
      results();
   end

   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      results();
   end
endmodule // pllcr_bench
